//--- pfmux_top.sv
// Shared pin function multiplexer with reset pin and clock output
//
// Summary of operation
// - After any reset every shared pin uses its primary function; alternates need programming.
// - During reset every pad has output driver off, input mode, pull-up on.
// - Each pin used as general I/O has its own direction bit.
// - Port B line 6 defaults to I/O; clock input needs selection and mode bit.
// - Selected as clock input, port B line 6 feeds the clock generation block.
// - Port B lines 7 and 4 default to I/O; peripherals chosen by selection.
// - In single-wire serial mode the transmit pin also carries received data, unless port B line 6 is selected as receive.
// - I2C data and clock each route to either of two pins.
// - Internal reset releases synchronously a fixed cycle count after reset ends.
// - Reset pin defaults to reset; as port A line 7 it is input or open drain.
// - With the reset pin in I/O mode, pin reset is ignored.
// - Clock output drives off, master clock, bus clock or oscillator clock.
`timescale 1ns/1ps
`default_nettype none

module pfmux_top #(
  parameter int RST_CYCLES = pfmux_pkg::RST_RELEASE_CYCLES
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // Register port
  input wire logic [pfmux_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic [pfmux_pkg::DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [pfmux_pkg::DATA_W-1:0] REG_RDATA_O,
  // Pad inputs
  input wire logic PB0_I,
  input wire logic PB1_I,
  input wire logic PB4_I,
  input wire logic PB6_I,
  input wire logic PB7_I,
  input wire logic PA7_I,
  // Pad drives
  output pfmux_pkg::pfmux_pad_t PB0_O,
  output pfmux_pkg::pfmux_pad_t PB1_O,
  output pfmux_pkg::pfmux_pad_t PB4_O,
  output pfmux_pkg::pfmux_pad_t PB6_O,
  output pfmux_pkg::pfmux_pad_t PB7_O,
  output pfmux_pkg::pfmux_pad_t PA7_O,
  // Clock sources and oscillator control
  input wire logic MASTER_CLK_I,
  input wire logic BUS_CLK_I,
  input wire logic OSC_CLK_I,
  input wire logic OSC_CLOCK_MODE_I,
  // Peripheral drives towards the pins
  input wire pfmux_pkg::pfmux_drv_t SCI_TXD_DRV_I,
  input wire logic SCI_SINGLE_WIRE_I,
  input wire pfmux_pkg::pfmux_drv_t I2C_SDA_DRV_I,
  input wire pfmux_pkg::pfmux_drv_t I2C_SCL_DRV_I,
  input wire pfmux_pkg::pfmux_drv_t SPI_SS_DRV_I,
  input wire pfmux_pkg::pfmux_drv_t SPI_SCLK_DRV_I,
  input wire pfmux_pkg::pfmux_drv_t TMR0_DRV_I,
  // Pin levels towards the peripherals
  output logic SCI_RXD_O,
  output logic I2C_SDA_O,
  output logic I2C_SCL_O,
  output logic SPI_SS_O,
  output logic SPI_SCLK_O,
  output logic TMR0_O,
  // Clock generation and system reset
  output logic EXT_CLK_O,
  output logic EXT_CLK_EN_O,
  output logic SYS_RST_O
);
  import pfmux_pkg::*;

  localparam int CNT_W = $clog2(RST_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RST_CYCLES - 1);
  function automatic logic [1:0] fsel(input logic [FUNC_W-1:0] f, input int idx);
    fsel = f[2*idx +: 2];
  endfunction
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [NPINS-1:0] data_q;
  logic [NPINS-1:0] dir_q;
  logic [FUNC_W-1:0] func_q;
  logic [1:0] clock_out_pin_sel_q;
  logic [DATA_W-1:0] rdata_q;
  logic [CNT_W-1:0] rst_cnt_q;
  logic sys_rst_q;
  pfmux_pad_t pad_q [NPINS];
  logic sci_rxd_q;
  logic sda_in_q;
  logic scl_in_q;
  logic ss_in_q;
  logic sclk_in_q;
  logic t0_in_q;
  logic ext_clk_en_q;
  logic clock_out_pin_mode_q;
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [NPINS-1:0] pin_s;
  pfmux_sync #(
    .W(NPINS)
  ) u_pin_sync (
    .clk_i(CORE_CLK_I),
    .d_i({PA7_I, PB7_I, PB6_I, PB4_I, PB1_I, PB0_I}),
    .q_o(pin_s)
  );

  // ------------------------------------------------------------
  // Function decode
  // ------------------------------------------------------------
  wire [1:0] fn_b0 = fsel(func_q, PIN_PB0);
  wire [1:0] fn_b1 = fsel(func_q, PIN_PB1);
  wire [1:0] fn_b4 = fsel(func_q, PIN_PB4);
  wire [1:0] fn_b6 = fsel(func_q, PIN_PB6);
  wire [1:0] fn_b7 = fsel(func_q, PIN_PB7);
  wire [1:0] fn_a7 = fsel(func_q, PIN_PA7);
  wire rst_pin_mode = (fn_a7 == FN_PRIMARY);
  wire a7_gpio = (fn_a7 == FN_A7_GPIO);

  // ------------------------------------------------------------
  // Reset request and release
  // ------------------------------------------------------------
  // Low pin holds reset
  wire rst_req = RST_I | (rst_pin_mode & ~pin_s[PIN_PA7]);
  wire reg_rst = RST_I | sys_rst_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (rst_req) begin
      rst_cnt_q <= '0;
      sys_rst_q <= 1'b1;
    end else if (sys_rst_q) begin
      rst_cnt_q <= rst_cnt_q + CNT_W'(1);
      sys_rst_q <= (rst_cnt_q != CNT_LAST);
    end
  end

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  wire wr_data = REG_WR_I & (REG_ADDR_I == OFS_GPIO_DATA);
  wire wr_dir = REG_WR_I & (REG_ADDR_I == OFS_GPIO_DIR);
  wire wr_func = REG_WR_I & (REG_ADDR_I == OFS_FUNC_SEL);
  wire wr_clock_out_pin = REG_WR_I & (REG_ADDR_I == OFS_CLOCK_OUT_PIN_SEL);

  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    case (REG_ADDR_I)
      OFS_GPIO_DATA: rd_mux = DATA_W'(data_q);
      OFS_GPIO_DIR: rd_mux = DATA_W'(dir_q);
      OFS_FUNC_SEL: rd_mux = DATA_W'(func_q);
      OFS_CLOCK_OUT_PIN_SEL: rd_mux = DATA_W'(clock_out_pin_sel_q);
      OFS_PIN_STATE: rd_mux = DATA_W'(pin_s);
      OFS_STATUS: begin
        rd_mux = '0;
        rd_mux[ST_EXT_CLK_EN] = ext_clk_en_q;
        rd_mux[ST_RST_PIN_MODE] = rst_pin_mode;
        rd_mux[ST_CLOCK_OUT_PIN_MODE] = clock_out_pin_mode_q;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (reg_rst) begin
      data_q <= RST_GPIO_DATA;
      dir_q <= RST_GPIO_DIR;
      func_q <= RST_FUNC_SEL;
      clock_out_pin_sel_q <= RST_CLOCK_OUT_PIN_SEL;
    end else begin
      if (wr_data) data_q <= REG_WDATA_I[NPINS-1:0];
      if (wr_dir) dir_q <= REG_WDATA_I[NPINS-1:0];
      if (wr_func) func_q <= REG_WDATA_I[FUNC_W-1:0];
      if (wr_clock_out_pin) clock_out_pin_sel_q <= REG_WDATA_I[1:0];
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= REG_RD_I ? rd_mux : '0;
    end
  end

  // ------------------------------------------------------------
  // Pad drive selection
  // ------------------------------------------------------------
  localparam pfmux_drv_t DRV_OFF = '{o: 1'b0, oe: 1'b0};
  localparam pfmux_drv_t DRV_ON_LOW = '{o: 1'b0, oe: 1'b1};
  pfmux_drv_t drv [NPINS];
  pfmux_drv_t gpio_drv [NPINS];

  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      gpio_drv[i] = '{o: data_q[i], oe: dir_q[i]};
    end
  end

  // Each pad driven by the source its function code selects
  always_comb begin
    case (fn_b0)
      FN_PRIMARY: drv[PIN_PB0] = gpio_drv[PIN_PB0];
      FN_B0_SCLK: drv[PIN_PB0] = SPI_SCLK_DRV_I;
      FN_B0_SCL: drv[PIN_PB0] = I2C_SCL_DRV_I;
      default: drv[PIN_PB0] = DRV_OFF;
    endcase
    case (fn_b1)
      FN_PRIMARY: drv[PIN_PB1] = gpio_drv[PIN_PB1];
      FN_B1_SS: drv[PIN_PB1] = SPI_SS_DRV_I;
      FN_B1_SDA: drv[PIN_PB1] = I2C_SDA_DRV_I;
      default: drv[PIN_PB1] = DRV_OFF;
    endcase
    case (fn_b4)
      FN_PRIMARY: drv[PIN_PB4] = gpio_drv[PIN_PB4];
      FN_B4_T0: drv[PIN_PB4] = TMR0_DRV_I;
      FN_B4_CLOCK_OUT_PIN: drv[PIN_PB4] = DRV_ON_LOW;
      default: drv[PIN_PB4] = DRV_OFF;
    endcase
    case (fn_b6)
      FN_PRIMARY: drv[PIN_PB6] = gpio_drv[PIN_PB6];
      FN_B6_SDA: drv[PIN_PB6] = I2C_SDA_DRV_I;
      default: drv[PIN_PB6] = DRV_OFF;
    endcase
    case (fn_b7)
      FN_PRIMARY: drv[PIN_PB7] = gpio_drv[PIN_PB7];
      FN_B7_TXD: drv[PIN_PB7] = SCI_TXD_DRV_I;
      FN_B7_SCL: drv[PIN_PB7] = I2C_SCL_DRV_I;
      default: drv[PIN_PB7] = DRV_OFF;
    endcase
    // Open drain: only ever pulls low
    if (a7_gpio) begin
      drv[PIN_PA7] = '{o: 1'b0, oe: dir_q[PIN_PA7] & ~data_q[PIN_PA7]};
    end else begin
      drv[PIN_PA7] = DRV_OFF;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    for (int i = 0; i < NPINS; i++) begin
      if (reg_rst) begin
        pad_q[i] <= '{o: 1'b0, oe: 1'b0, pu: 1'b1};
      end else begin
        pad_q[i] <= '{o: drv[i].o, oe: drv[i].oe, pu: ~drv[i].oe};
      end
    end
  end

  // ------------------------------------------------------------
  // Pin levels towards peripherals
  // ------------------------------------------------------------
  // Single-wire receive from transmit pad
  wire rxd_d = (fn_b6 == FN_B6_RXD) ? pin_s[PIN_PB6] :
               ((fn_b7 == FN_B7_TXD) & SCI_SINGLE_WIRE_I) ? pin_s[PIN_PB7] : 1'b1;
  // Data and clock from whichever pin carries them
  wire sda_d = (fn_b6 == FN_B6_SDA) ? pin_s[PIN_PB6] :
               (fn_b1 == FN_B1_SDA) ? pin_s[PIN_PB1] : 1'b1;
  wire scl_d = (fn_b7 == FN_B7_SCL) ? pin_s[PIN_PB7] :
               (fn_b0 == FN_B0_SCL) ? pin_s[PIN_PB0] : 1'b1;
  wire ss_d = (fn_b1 == FN_B1_SS) ? pin_s[PIN_PB1] : 1'b1;
  wire sclk_d = (fn_b0 == FN_B0_SCLK) ? pin_s[PIN_PB0] : 1'b0;
  wire t0_d = (fn_b4 == FN_B4_T0) ? pin_s[PIN_PB4] : 1'b0;
  // Clock input needs both selection and mode bit
  wire ext_clk_en_d = (fn_b6 == FN_B6_EXT_CLOCK_IN) & OSC_CLOCK_MODE_I;

  always_ff @(posedge CORE_CLK_I) begin
    if (reg_rst) begin
      sci_rxd_q <= 1'b1;
      sda_in_q <= 1'b1;
      scl_in_q <= 1'b1;
      ss_in_q <= 1'b1;
      sclk_in_q <= 1'b0;
      t0_in_q <= 1'b0;
      ext_clk_en_q <= 1'b0;
      clock_out_pin_mode_q <= 1'b0;
    end else begin
      sci_rxd_q <= rxd_d;
      sda_in_q <= sda_d;
      scl_in_q <= scl_d;
      ss_in_q <= ss_d;
      sclk_in_q <= sclk_d;
      t0_in_q <= t0_d;
      ext_clk_en_q <= ext_clk_en_d;
      clock_out_pin_mode_q <= (fn_b4 == FN_B4_CLOCK_OUT_PIN);
    end
  end

  // ------------------------------------------------------------
  // Clock output
  // ------------------------------------------------------------
  logic clock_out_pin_clk;
  pfmux_clkout u_clkout (
    .sel_i(clock_out_pin_sel_q),
    .master_clk_i(MASTER_CLK_I),
    .bus_clk_i(BUS_CLK_I),
    .osc_clk_i(OSC_CLK_I),
    .clk_o(clock_out_pin_clk)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Clock paths bypass flops: a clock cannot be resampled at its own rate
  assign PB0_O = pad_q[PIN_PB0];
  assign PB1_O = pad_q[PIN_PB1];
  assign PB4_O = '{o: clock_out_pin_mode_q ? clock_out_pin_clk : pad_q[PIN_PB4].o,
                   oe: pad_q[PIN_PB4].oe, pu: pad_q[PIN_PB4].pu};
  assign PB6_O = pad_q[PIN_PB6];
  assign PB7_O = pad_q[PIN_PB7];
  assign PA7_O = pad_q[PIN_PA7];
  assign REG_RDATA_O = rdata_q;
  assign SCI_RXD_O = sci_rxd_q;
  assign I2C_SDA_O = sda_in_q;
  assign I2C_SCL_O = scl_in_q;
  assign SPI_SS_O = ss_in_q;
  assign SPI_SCLK_O = sclk_in_q;
  assign TMR0_O = t0_in_q;
  assign EXT_CLK_EN_O = ext_clk_en_q;
  // Raw pad clock to clock generation
  assign EXT_CLK_O = ext_clk_en_q & PB6_I;
  assign SYS_RST_O = sys_rst_q;

endmodule

`default_nettype wire

//--- pfmux_pkg.sv
// Constants and carrier types of the pin function multiplexer
`default_nettype none

package pfmux_pkg;

  // ------------------------------------------------------------
  // Bus and register widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int NPINS = 6;
  localparam int FUNC_W = 2 * NPINS;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_GPIO_DATA = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_GPIO_DIR = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_FUNC_SEL = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_OUT_PIN_SEL = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_PIN_STATE = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h5;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [NPINS-1:0] RST_GPIO_DATA = 6'h00;
  localparam logic [NPINS-1:0] RST_GPIO_DIR = 6'h00;
  localparam logic [FUNC_W-1:0] RST_FUNC_SEL = 12'h000;
  localparam logic [1:0] RST_CLOCK_OUT_PIN_SEL = 2'h0;

  // ------------------------------------------------------------
  // Pin positions in data, direction and state registers
  // ------------------------------------------------------------
  localparam int PIN_PB0 = 0;
  localparam int PIN_PB1 = 1;
  localparam int PIN_PB4 = 2;
  localparam int PIN_PB6 = 3;
  localparam int PIN_PB7 = 4;
  localparam int PIN_PA7 = 5;

  // Status register bits
  localparam int ST_EXT_CLK_EN = 0;
  localparam int ST_RST_PIN_MODE = 1;
  localparam int ST_CLOCK_OUT_PIN_MODE = 2;

  // ------------------------------------------------------------
  // Function codes, two bits per pin, code 0 is the primary use
  // ------------------------------------------------------------
  localparam logic [1:0] FN_PRIMARY = 2'h0;
  localparam logic [1:0] FN_B0_SCLK = 2'h1;
  localparam logic [1:0] FN_B0_SCL = 2'h2;
  localparam logic [1:0] FN_B1_SS = 2'h1;
  localparam logic [1:0] FN_B1_SDA = 2'h2;
  localparam logic [1:0] FN_B4_T0 = 2'h1;
  localparam logic [1:0] FN_B4_CLOCK_OUT_PIN = 2'h2;
  localparam logic [1:0] FN_B6_RXD = 2'h1;
  localparam logic [1:0] FN_B6_SDA = 2'h2;
  localparam logic [1:0] FN_B6_EXT_CLOCK_IN = 2'h3;
  localparam logic [1:0] FN_B7_TXD = 2'h1;
  localparam logic [1:0] FN_B7_SCL = 2'h2;
  localparam logic [1:0] FN_A7_GPIO = 2'h1;

  // Clock output source codes
  localparam logic [1:0] CLOCK_OUT_PIN_OFF = 2'h0;
  localparam logic [1:0] CLOCK_OUT_PIN_MASTER = 2'h1;
  localparam logic [1:0] CLOCK_OUT_PIN_BUS = 2'h2;
  localparam logic [1:0] CLOCK_OUT_PIN_OSC = 2'h3;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int RST_RELEASE_CYCLES = 32;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic o;
    logic oe;
  } pfmux_drv_t;

  typedef struct packed {
    logic o;
    logic oe;
    logic pu;
  } pfmux_pad_t;

endpackage

`default_nettype wire

//--- pfmux_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module pfmux_sync #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // No reset: pin levels must be tracked while the chip is held in reset
  always_ff @(posedge clk_i) begin
    meta_q <= d_i;
    q_o <= meta_q;
  end

endmodule

`default_nettype wire

//--- pfmux_clkout.sv
// Source selector for the buffered clock output
`timescale 1ns/1ps
`default_nettype none

module pfmux_clkout (
  // Selection
  input wire logic [1:0] sel_i,
  // Clock sources
  input wire logic master_clk_i,
  input wire logic bus_clk_i,
  input wire logic osc_clk_i,
  // Selected clock
  output logic clk_o
);
  import pfmux_pkg::*;

  always_comb begin
    case (sel_i)
      CLOCK_OUT_PIN_MASTER: clk_o = master_clk_i;
      CLOCK_OUT_PIN_BUS: clk_o = bus_clk_i;
      CLOCK_OUT_PIN_OSC: clk_o = osc_clk_i;
      default: clk_o = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

//--- pfmux_asserts.sv
// Checker for the pin multiplexer top-level ports
`timescale 1ns/1ps
`default_nettype none

module pfmux_asserts #(
  parameter int RST_CYCLES = 2
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic SYS_RST_O,
  // Pins and clock path
  input wire logic PB6_I,
  input wire logic OSC_CLOCK_MODE_I,
  input wire pfmux_pkg::pfmux_pad_t PB0_O,
  input wire pfmux_pkg::pfmux_pad_t PB4_O,
  input wire pfmux_pkg::pfmux_pad_t PB7_O,
  input wire pfmux_pkg::pfmux_pad_t PA7_O,
  input wire logic SCI_RXD_O,
  input wire logic EXT_CLK_O,
  input wire logic EXT_CLK_EN_O
);
  import pfmux_pkg::*;
  // ------------------------------------------------------------
  // Release counter
  // ------------------------------------------------------------
  logic [7:0] rel_q;
  logic src_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I)
      rel_q <= 8'h00;
    else if (SYS_RST_O)
      rel_q <= rel_q + 8'h01;
    if (RST_I)
      src_q <= 1'b1;
    else if (!SYS_RST_O)
      src_q <= 1'b0;
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  chk_rst_enter: assert property (disable iff (1'b0) RST_I |=> SYS_RST_O)
    else $error("reset input did not raise system reset");
  chk_rst_release: assert property ($fell(SYS_RST_O) && src_q |-> rel_q == 8'(RST_CYCLES))
    else $error("system reset released after wrong cycle count");
  chk_reset_pads: assert property (disable iff (1'b0) SYS_RST_O && $past(SYS_RST_O) |->
    !PB0_O.oe && !PB4_O.oe && !PB7_O.oe && !PA7_O.oe && PB0_O.pu && PB7_O.pu)
    else $error("pad driven or unpulled during reset");
  chk_primary_after: assert property ($fell(SYS_RST_O) |=>
    !PB4_O.oe && !PB7_O.oe && !EXT_CLK_EN_O && SCI_RXD_O)
    else $error("pins not in primary use after reset");
  chk_ext_clock_in_mode: assert property (EXT_CLK_EN_O |-> $past(OSC_CLOCK_MODE_I))
    else $error("clock input enabled without mode bit");
  chk_ext_clock_in_gate: assert property (EXT_CLK_O == (PB6_I && EXT_CLK_EN_O))
    else $error("external clock path wrong");
  chk_pa7_drain: assert property (PA7_O.o == 1'b0)
    else $error("reset pin drives high");
  chk_pullup_inv: assert property (PB7_O.pu == !PB7_O.oe)
    else $error("pull-up not tied to input mode");
  cover property ($fell(SYS_RST_O));
  cover property (EXT_CLK_EN_O && PB6_I);
  cover property (PB4_O.oe && PB4_O.o);
endmodule

`default_nettype wire

//--- pfmux_board.sv
// Board model resolving each shared pin to a level
`timescale 1ns/1ps
`default_nettype none

module pfmux_board (
  // Clock
  input wire logic clk_i,
  // Pads from the device
  input wire pfmux_pkg::pfmux_pad_t pad_i [6],
  // Outside drivers
  input wire logic [5:0] ext_en_i,
  input wire logic [5:0] ext_v_i,
  // Resolved levels
  output logic [5:0] lvl_o
);
  import pfmux_pkg::*;
  logic [5:0] last_q;
  always_ff @(posedge clk_i) last_q <= lvl_o;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pad_i[i].oe)
        lvl_o[i] = pad_i[i].o;
      else if (ext_en_i[i])
        lvl_o[i] = ext_v_i[i];
      else if (pad_i[i].pu)
        lvl_o[i] = 1'b1;
      else
        lvl_o[i] = ~last_q[i];
    end
  end
endmodule

`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import pfmux_pkg::*;
  localparam int RC = 2;
  logic clk, rst, wr, rd, mode, sw, mclk, bclk, oclk;
  logic rxd_o, sda_o, scl_o, eclk, eclk_en, sys_rst;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, v;
  logic [5:0] ext_en, ext_v, lvl;
  pfmux_pad_t pad [6];
  pfmux_drv_t txd, sda, scl, tmr;
  int n_mismatch = 0;
  int total_checks = 0;
  pfmux_top #(.RST_CYCLES(RC)) DUT (
    .CORE_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .PB0_I(lvl[PIN_PB0]), .PB1_I(lvl[PIN_PB1]), .PB4_I(lvl[PIN_PB4]),
    .PB6_I(lvl[PIN_PB6]), .PB7_I(lvl[PIN_PB7]), .PA7_I(lvl[PIN_PA7]),
    .PB0_O(pad[PIN_PB0]), .PB1_O(pad[PIN_PB1]), .PB4_O(pad[PIN_PB4]),
    .PB6_O(pad[PIN_PB6]), .PB7_O(pad[PIN_PB7]), .PA7_O(pad[PIN_PA7]),
    .MASTER_CLK_I(mclk), .BUS_CLK_I(bclk), .OSC_CLK_I(oclk), .OSC_CLOCK_MODE_I(mode),
    .SCI_TXD_DRV_I(txd), .SCI_SINGLE_WIRE_I(sw), .I2C_SDA_DRV_I(sda),
    .I2C_SCL_DRV_I(scl), .SPI_SS_DRV_I(2'h0), .SPI_SCLK_DRV_I(2'h0), .TMR0_DRV_I(tmr),
    .SCI_RXD_O(rxd_o), .I2C_SDA_O(sda_o), .I2C_SCL_O(scl_o), .SPI_SS_O(), .SPI_SCLK_O(),
    .TMR0_O(), .EXT_CLK_O(eclk), .EXT_CLK_EN_O(eclk_en), .SYS_RST_O(sys_rst)
  );
  pfmux_board u_board (.clk_i(clk), .pad_i(pad), .ext_en_i(ext_en), .ext_v_i(ext_v),
    .lvl_o(lvl));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic ext(input int p, input logic en, input logic val);
    @(posedge clk);
    ext_en[p] <= en;
    ext_v[p] <= val;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_defaults();
    for (int a = 0; a < 4; a++) begin
      rreg(4'(a), v);
      chk("reset value", v, 16'h0000);
    end
    rreg(OFS_PIN_STATE, v);
    chk("pin state", v, 16'h003f);
    rreg(4'hf, v);
    chk("unmapped", v, 16'h0000);
    chk("pb6 pad", 16'(pad[PIN_PB6].oe), 16'h0000);
    chk("pb7 pad", 16'(pad[PIN_PB7].oe), 16'h0000);
  endtask
  task automatic t_gpio();
    wreg(OFS_GPIO_DATA, 16'h003f);
    wreg(OFS_GPIO_DIR, 16'h0001);
    cyc(2);
    chk("pb0 out", 16'(pad[PIN_PB0]), 16'h0006);
    chk("pb1 in", 16'(pad[PIN_PB1].oe), 16'h0000);
    wreg(OFS_GPIO_DIR, 16'h0002);
    cyc(2);
    chk("pb1 out", 16'(pad[PIN_PB1]), 16'h0006);
    chk("pb0 in", 16'(pad[PIN_PB0].oe), 16'h0000);
  endtask
  task automatic t_periph();
    wreg(OFS_GPIO_DATA, 16'h0000);
    wreg(OFS_GPIO_DIR, 16'h003f);
    @(posedge clk);
    tmr <= 2'h1;
    wreg(OFS_FUNC_SEL, 16'h001a);
    cyc(2);
    chk("timer pad", 16'(pad[PIN_PB4]), 16'h0002);
    chk("scl pad off", 16'(pad[PIN_PB0].oe), 16'h0000);
    ext(PIN_PB1, 1'b1, 1'b0);
    ext(PIN_PB0, 1'b1, 1'b0);
    cyc(4);
    chk("sda on pb1", 16'(sda_o), 16'h0000);
    chk("scl on pb0", 16'(scl_o), 16'h0000);
    wreg(OFS_FUNC_SEL, 16'h0280);
    ext(PIN_PB6, 1'b1, 1'b1);
    ext(PIN_PB7, 1'b1, 1'b1);
    cyc(4);
    chk("sda on pb6", 16'(sda_o), 16'h0001);
    chk("scl on pb7", 16'(scl_o), 16'h0001);
    wreg(OFS_FUNC_SEL, 16'h0000);
    wreg(OFS_GPIO_DIR, 16'h0000);
    ext_en <= 6'h00;
  endtask
  task automatic t_ext_clock_in();
    wreg(OFS_FUNC_SEL, 16'h00c0);
    ext(PIN_PB6, 1'b1, 1'b1);
    cyc(2);
    chk("clk in no mode", 16'(eclk_en), 16'h0000);
    @(posedge clk);
    mode <= 1'b1;
    cyc(2);
    chk("clk in enabled", 16'(eclk_en), 16'h0001);
    chk("clk in level", 16'(eclk), 16'h0001);
    rreg(OFS_STATUS, v);
    chk("status clk in", v, 16'h0003);
    wreg(OFS_FUNC_SEL, 16'h0000);
    cyc(2);
    chk("clk in unselected", 16'(eclk_en), 16'h0000);
    @(posedge clk);
    mode <= 1'b0;
    ext_en <= 6'h00;
  endtask
  task automatic t_single();
    wreg(OFS_FUNC_SEL, 16'h0100);
    @(posedge clk);
    sw <= 1'b1;
    txd <= 2'h3;
    cyc(2);
    chk("txd pad", 16'(pad[PIN_PB7]), 16'h0006);
    @(posedge clk);
    txd <= 2'h0;
    ext(PIN_PB7, 1'b1, 1'b0);
    cyc(4);
    chk("rx on tx pin low", 16'(rxd_o), 16'h0000);
    ext(PIN_PB7, 1'b1, 1'b1);
    cyc(4);
    chk("rx on tx pin high", 16'(rxd_o), 16'h0001);
    @(posedge clk);
    sw <= 1'b0;
    ext_en <= 6'h00;
    wreg(OFS_FUNC_SEL, 16'h0000);
  endtask
  task automatic t_clkout();
    logic [2:0] src;
    logic e;
    wreg(OFS_FUNC_SEL, 16'h0020);
    for (int p = 0; p < 2; p++) begin
      src = (p == 1) ? 3'h2 : 3'h5;
      @(posedge clk);
      mclk <= src[2];
      bclk <= src[1];
      oclk <= src[0];
      for (int s = 0; s < 4; s++) begin
        wreg(OFS_CLOCK_OUT_PIN_SEL, 16'(s));
        cyc(2);
        e = (s == 0) ? 1'b0 : src[3-s];
        chk("clock out", 16'(pad[PIN_PB4].o), 16'(e));
        chk("clock out oe", 16'(pad[PIN_PB4].oe), 16'h0001);
      end
    end
    rreg(OFS_STATUS, v);
    chk("status clock out", v, 16'h0006);
    wreg(OFS_CLOCK_OUT_PIN_SEL, 16'h0000);
    wreg(OFS_FUNC_SEL, 16'h0000);
  endtask
  task automatic t_pin_reset();
    int n;
    wreg(OFS_FUNC_SEL, 16'h0010);
    ext(PIN_PA7, 1'b1, 1'b0);
    n = 0;
    while (sys_rst !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk("pin reset", 16'(sys_rst), 16'h0001);
    ext(PIN_PA7, 1'b0, 1'b0);
    n = 0;
    while (sys_rst !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("release delay", 16'(n >= RC && n <= RC + 5), 16'h0001);
    rreg(OFS_FUNC_SEL, v);
    chk("func after pin reset", v, 16'h0000);
    wreg(OFS_FUNC_SEL, 16'h0400);
    ext(PIN_PA7, 1'b1, 1'b0);
    cyc(8);
    chk("pin reset ignored", 16'(sys_rst), 16'h0000);
    ext(PIN_PA7, 1'b0, 1'b0);
    wreg(OFS_GPIO_DATA, 16'h0000);
    wreg(OFS_GPIO_DIR, 16'h0020);
    cyc(2);
    chk("pa7 pulls low", 16'(pad[PIN_PA7]), 16'h0002);
    wreg(OFS_GPIO_DATA, 16'h0020);
    cyc(2);
    chk("pa7 released", 16'(pad[PIN_PA7].oe), 16'h0000);
  endtask
  // ------------------------------------------------------------
  // Clock, sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rst, wr, rd, mode, sw, mclk, bclk, oclk} = 8'h80;
    addr = 4'h0;
    wdata = 16'h0000;
    {ext_en, ext_v} = 12'h000;
    {txd, sda, scl, tmr} = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cyc(RC + 6);
    t_defaults();
    t_gpio();
    t_periph();
    t_ext_clock_in();
    t_single();
    t_clkout();
    t_pin_reset();
    close_out();
  end
  initial begin
    #2000000;
    n_mismatch++;
    close_out();
  end
endmodule

bind pfmux_top pfmux_asserts #(.RST_CYCLES(RST_CYCLES)) u_chk (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .SYS_RST_O(SYS_RST_O), .PB6_I(PB6_I),
  .OSC_CLOCK_MODE_I(OSC_CLOCK_MODE_I), .PB0_O(PB0_O), .PB4_O(PB4_O), .PB7_O(PB7_O),
  .PA7_O(PA7_O), .SCI_RXD_O(SCI_RXD_O), .EXT_CLK_O(EXT_CLK_O), .EXT_CLK_EN_O(EXT_CLK_EN_O)
);

`default_nettype wire
